//--- rtl/bkb_pkg.sv
// Package: register map, field layout and reset values of the channel B match block
package bkb_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_TARGET_ADDR = 8'h00;
    localparam logic [7:0] OFF_ADDR_MASK   = 8'h04;
    localparam logic [7:0] OFF_TARGET_DATA = 8'h08;
    localparam logic [7:0] OFF_DATA_MASK   = 8'h0c;
    localparam logic [7:0] OFF_QUALIFIER   = 8'h10;
    localparam logic [7:0] OFF_MATCH_FLAGS = 8'h14;
    localparam logic [7:0] OFF_INT_MASK    = 8'h18;

    // ************************************************************
    // Qualifier field positions
    // ************************************************************
    localparam int QUAL_BUS_POS  = 6;
    localparam int QUAL_FD_POS   = 4;
    localparam int QUAL_DIR_POS  = 2;
    localparam int QUAL_SIZE_POS = 0;
    localparam int QUAL_WIDTH    = 8;

    // Match flag positions inside the flag register
    localparam int FLAG_LOCAL_POS    = 14;
    localparam int FLAG_INTERNAL_POS = 12;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0]  RST_QUAL = 8'h00;

    // ************************************************************
    // Field encodings
    // ************************************************************
    typedef enum logic [1:0] {
        BKB_BUS_OFF      = 2'h0,
        BKB_BUS_LOCAL    = 2'h1,
        BKB_BUS_INTERNAL = 2'h2,
        BKB_BUS_LOCAL2   = 2'h3
    } bkb_bus_sel_t;

    typedef enum logic [1:0] {
        BKB_SIZE_ANY  = 2'h0,
        BKB_SIZE_BYTE = 2'h1,
        BKB_SIZE_WORD = 2'h2,
        BKB_SIZE_LONG = 2'h3
    } bkb_size_t;

endpackage : bkb_pkg

//--- rtl/bkb_match.sv
// Channel B break-condition registers, comparators and sticky match flags
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps

module bkb_match
    import bkb_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Local bus cycle
    input  wire logic        lcl_valid,
    input  wire logic [31:0] local_address_bus,
    input  wire logic [31:0] local_data_bus,
    input  wire logic        lcl_fetch,
    input  wire logic        lcl_write,
    input  wire logic [1:0]  lcl_size,
    // Internal bus cycle
    input  wire logic        int_valid,
    input  wire logic [31:0] internal_address_bus,
    input  wire logic [31:0] internal_data_bus,
    input  wire logic        int_fetch,
    input  wire logic        int_write,
    input  wire logic [1:0]  int_size,
    // Match results
    output logic             local_bus_match_flag_chan2,
    output logic             internal_bus_match_flag_chan2,
    output logic             irq
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0]           chan_b_target_address_reg;
    logic [31:0]           chan_b_address_mask_reg;
    logic [31:0]           chan_b_target_data_reg;
    logic [31:0]           chan_b_data_mask_reg;
    logic [QUAL_WIDTH-1:0] chan_b_cycle_qualifier_reg;
    logic [1:0]            int_mask_reg;
    logic                  flag_local_reg;
    logic                  flag_internal_reg;

    logic       wr_en;
    logic       rd_en;
    logic       wr_target_addr;
    logic       wr_addr_mask;
    logic       wr_target_data;
    logic       wr_data_mask;
    logic       wr_qualifier;
    logic       wr_flags;
    logic       wr_int_mask;
    logic       addr_hit;
    logic [1:0] match_hit;
    logic [1:0] bus_want;
    logic [1:0] bus_sel;
    logic [1:0] fd_sel;
    logic [1:0] dir_sel;
    logic [1:0] size_sel;

    // Zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    // Read word is captured in setup so it stands through the access phase
    assign rd_en   = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !addr_hit;

    always_comb begin
        unique case (paddr)
            OFF_TARGET_ADDR, OFF_ADDR_MASK, OFF_TARGET_DATA, OFF_DATA_MASK,
            OFF_QUALIFIER, OFF_MATCH_FLAGS, OFF_INT_MASK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // ************************************************************
    // Write strobes
    // ************************************************************
    assign wr_target_addr = wr_en && (paddr == OFF_TARGET_ADDR);
    assign wr_addr_mask   = wr_en && (paddr == OFF_ADDR_MASK);
    assign wr_target_data = wr_en && (paddr == OFF_TARGET_DATA);
    assign wr_data_mask   = wr_en && (paddr == OFF_DATA_MASK);
    assign wr_qualifier   = wr_en && (paddr == OFF_QUALIFIER);
    assign wr_flags       = wr_en && (paddr == OFF_MATCH_FLAGS);
    assign wr_int_mask    = wr_en && (paddr == OFF_INT_MASK);

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_b_target_address_reg <= RST_WORD;
        end else if (wr_target_addr) begin
            chan_b_target_address_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_b_address_mask_reg <= RST_WORD;
        end else if (wr_addr_mask) begin
            chan_b_address_mask_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_b_target_data_reg <= RST_WORD;
        end else if (wr_target_data) begin
            chan_b_target_data_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_b_data_mask_reg <= RST_WORD;
        end else if (wr_data_mask) begin
            chan_b_data_mask_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_b_cycle_qualifier_reg <= RST_QUAL;
        end else if (wr_qualifier) begin
            // Upper qualifier bits are not stored at all
            chan_b_cycle_qualifier_reg <= pwdata[QUAL_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_reg <= 2'h0;
        end else if (wr_int_mask) begin
            int_mask_reg <= {pwdata[FLAG_LOCAL_POS], pwdata[FLAG_INTERNAL_POS]};
        end
    end

    // ************************************************************
    // Cycle qualification and comparison
    // ************************************************************
    assign bus_sel  = chan_b_cycle_qualifier_reg[QUAL_BUS_POS +: 2];
    assign fd_sel   = chan_b_cycle_qualifier_reg[QUAL_FD_POS +: 2];
    assign dir_sel  = chan_b_cycle_qualifier_reg[QUAL_DIR_POS +: 2];
    assign size_sel = chan_b_cycle_qualifier_reg[QUAL_SIZE_POS +: 2];

    // Index 1 is the local bus, index 0 the internal bus
    always_comb begin
        unique case (bkb_bus_sel_t'(bus_sel))
            BKB_BUS_OFF:      bus_want = 2'b00;
            BKB_BUS_LOCAL:    bus_want = 2'b10;
            BKB_BUS_INTERNAL: bus_want = 2'b01;
            BKB_BUS_LOCAL2:   bus_want = 2'b10;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_bus
            logic        cyc_valid;
            logic [31:0] cyc_addr;
            logic [31:0] cyc_data;
            logic        cyc_fetch;
            logic        cyc_write;
            logic [1:0]  cyc_size;
            logic        fd_ok;
            logic        dir_ok;
            logic        addr_ok;
            logic        data_ok;
            logic [3:0]  lane_eq;

            assign cyc_valid = (g == 1) ? lcl_valid : int_valid;
            assign cyc_addr  = (g == 1) ? local_address_bus : internal_address_bus;
            assign cyc_data  = (g == 1) ? local_data_bus : internal_data_bus;
            assign cyc_fetch = (g == 1) ? lcl_fetch : int_fetch;
            assign cyc_write = (g == 1) ? lcl_write : int_write;
            assign cyc_size  = (g == 1) ? lcl_size : int_size;

            // A zero field means no cycle of that kind qualifies
            assign fd_ok  = cyc_fetch ? fd_sel[0] : fd_sel[1];
            assign dir_ok = cyc_write ? dir_sel[1] : dir_sel[0];

            assign addr_ok = ((cyc_addr ^ chan_b_target_address_reg)
                              & ~chan_b_address_mask_reg) == 32'h0000_0000;

            // Masked equality per byte lane; the size code picks the lanes
            for (genvar k = 0; k < 4; k++) begin : g_lane
                assign lane_eq[k] = ((cyc_data[8*k +: 8] ^ chan_b_target_data_reg[8*k +: 8])
                                     & ~chan_b_data_mask_reg[8*k +: 8]) == 8'h00;
            end

            // Data only takes part once a size is programmed; byte compare
            // looks at the low lane, relying on software replicating it
            always_comb begin
                unique case (bkb_size_t'(size_sel))
                    BKB_SIZE_ANY:  data_ok = 1'b1;
                    BKB_SIZE_BYTE: data_ok = (cyc_size == BKB_SIZE_BYTE) && lane_eq[0];
                    BKB_SIZE_WORD: data_ok = (cyc_size == BKB_SIZE_WORD) && (&lane_eq[1:0]);
                    BKB_SIZE_LONG: data_ok = (cyc_size == BKB_SIZE_LONG) && (&lane_eq);
                endcase
            end

            assign match_hit[g] = cyc_valid && bus_want[g] && fd_ok && dir_ok
                                  && addr_ok && data_ok;
        end
    endgenerate

    // ************************************************************
    // Sticky match flags: a hit wins over a clear in the same cycle
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_local_reg <= 1'b0;
        end else if (match_hit[1]) begin
            flag_local_reg <= 1'b1;
        end else if (wr_flags && !pwdata[FLAG_LOCAL_POS]) begin
            flag_local_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_internal_reg <= 1'b0;
        end else if (match_hit[0]) begin
            flag_internal_reg <= 1'b1;
        end else if (wr_flags && !pwdata[FLAG_INTERNAL_POS]) begin
            flag_internal_reg <= 1'b0;
        end
    end

    assign local_bus_match_flag_chan2    = flag_local_reg;
    assign internal_bus_match_flag_chan2 = flag_internal_reg;
    assign irq = (flag_local_reg && int_mask_reg[1]) || (flag_internal_reg && int_mask_reg[0]);

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RST_WORD;
        end else if (rd_en) begin
            prdata <= RST_WORD;
            unique case (paddr)
                OFF_TARGET_ADDR: prdata <= chan_b_target_address_reg;
                OFF_ADDR_MASK:   prdata <= chan_b_address_mask_reg;
                OFF_TARGET_DATA: prdata <= chan_b_target_data_reg;
                OFF_DATA_MASK:   prdata <= chan_b_data_mask_reg;
                OFF_QUALIFIER:   prdata <= {24'h00_0000, chan_b_cycle_qualifier_reg};
                OFF_MATCH_FLAGS: begin
                    prdata[FLAG_LOCAL_POS]    <= flag_local_reg;
                    prdata[FLAG_INTERNAL_POS] <= flag_internal_reg;
                end
                OFF_INT_MASK: begin
                    prdata[FLAG_LOCAL_POS]    <= int_mask_reg[1];
                    prdata[FLAG_INTERNAL_POS] <= int_mask_reg[0];
                end
                default: ;
            endcase
        end
    end

endmodule : bkb_match

//--- tb/bkb_match_assertions.sv
// Port checker for the channel B match block
`timescale 1ns/1ps
module bkb_match_chk (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Bus cycles and results
    input wire logic        lcl_valid,
    input wire logic        int_valid,
    input wire logic        local_bus_match_flag_chan2,
    input wire logic        internal_bus_match_flag_chan2,
    input wire logic        irq
);
    wire lf = local_bus_match_flag_chan2;
    wire nf = internal_bus_match_flag_chan2;
    wire fw = psel && penable && pwrite && paddr == 8'h14;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************
    // Flags
    // ****************
    a_local_set: assert property ($rose(lf) |-> $past(lcl_valid)) else $error("local flag set idle");
    a_int_set: assert property ($rose(nf) |-> $past(int_valid)) else $error("internal flag set idle");
    a_local_hold: assert property (lf && !(fw && !pwdata[14]) |=> lf) else $error("local flag lost");
    a_int_hold: assert property (nf && !(fw && !pwdata[12]) |=> nf) else $error("internal flag lost");
    a_local_clear: assert property (fw && !pwdata[14] && !lcl_valid |=> !lf) else $error("flag not cleared");
    a_irq_source: assert property (irq |-> lf || nf) else $error("irq without flag");
    a_qual_upper: assert property (psel && penable && !pwrite && paddr == 8'h10 |-> prdata[31:8] == 24'h0)
        else $error("qualifier upper bits set");
    a_reset_clear: assert property ($rose(presetn) |-> !lf && !nf && !irq) else $error("not clear at reset");
    c_local: cover property ($rose(lf));
    c_int: cover property ($rose(nf));
    c_irq: cover property ($rose(irq));
endmodule : bkb_match_chk
bind bkb_match bkb_match_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .lcl_valid, .int_valid, .local_bus_match_flag_chan2, .internal_bus_match_flag_chan2, .irq);

//--- tb/bkb_bus_model.sv
// Behavioural CPU local and internal bus driver
`timescale 1ns/1ps
module bkb_bus_model (
    input  wire logic   pclk,
    output logic        lcl_valid,
    output logic [31:0] local_address_bus,
    output logic [31:0] local_data_bus,
    output logic        lcl_fetch,
    output logic        lcl_write,
    output logic [1:0]  lcl_size,
    output logic        int_valid,
    output logic [31:0] internal_address_bus,
    output logic [31:0] internal_data_bus,
    output logic        int_fetch,
    output logic        int_write,
    output logic [1:0]  int_size
);
    initial begin
        {lcl_valid, local_address_bus, local_data_bus, lcl_fetch, lcl_write, lcl_size} = '0;
        {int_valid, internal_address_bus, internal_data_bus, int_fetch, int_write, int_size} = '0;
    end
    // One cycle on bus c[4] (0 local); c[3] fetch, c[2] write, c[1:0] size
    task automatic cyc(input logic [4:0] c, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        lcl_valid <= !c[4];
        int_valid <= c[4];
        {local_address_bus, local_data_bus, lcl_fetch, lcl_write, lcl_size} <= {a, d, c[3:0]};
        {internal_address_bus, internal_data_bus, int_fetch, int_write, int_size} <= {a, d, c[3:0]};
        @(posedge pclk);
        lcl_valid <= 1'b0;
        int_valid <= 1'b0;
        // Released lines invert so a stale value never looks like a hit
        {local_address_bus, local_data_bus, lcl_fetch, lcl_write, lcl_size} <= ~{a, d, c[3:0]};
        {internal_address_bus, internal_data_bus, int_fetch, int_write, int_size} <= ~{a, d, c[3:0]};
    endtask : cyc
endmodule : bkb_bus_model

//--- tb/tb_top.sv
// Testbench for the channel B match block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
    import bkb_pkg::*;
    localparam logic [31:0] TA = 32'h1234_5678;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_seen;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        lcl_valid, lcl_fetch, lcl_write, int_valid, int_fetch, int_write;
    logic [1:0]  lcl_size, int_size;
    logic [31:0] local_address_bus, local_data_bus, internal_address_bus, internal_data_bus;
    logic        local_bus_match_flag_chan2, internal_bus_match_flag_chan2;
    int          num_errors, n_compared, ticks;
    bkb_match u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .lcl_valid, .local_address_bus, .local_data_bus, .lcl_fetch, .lcl_write, .lcl_size,
        .int_valid, .internal_address_bus, .internal_data_bus, .int_fetch, .int_write, .int_size,
        .local_bus_match_flag_chan2, .internal_bus_match_flag_chan2, .irq);
    bkb_bus_model u_bm (.pclk, .lcl_valid, .local_address_bus, .local_data_bus, .lcl_fetch, .lcl_write,
        .lcl_size, .int_valid, .internal_address_bus, .internal_data_bus, .int_fetch, .int_write, .int_size);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        ticks <= ticks + 1;
        if (ticks == 3000) begin
            num_errors++;
            close_out();
        end
    end
    // ****************
    // Tasks
    // ****************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, q);
    endtask : rd
    // Qualifier qu, cycle c, address bits XORed into TA x, bus data d, expected hit e
    task automatic hit(input logic [7:0] qu, input logic [4:0] c, input logic [31:0] x, d, input logic e);
        apb(1'b1, OFF_QUALIFIER, {24'h0, qu});
        u_bm.cyc(c, TA ^ x, d);
        #1;
        `CHK("local flag", c[4] ? 1'b0 : e, local_bus_match_flag_chan2);
        `CHK("internal flag", c[4] ? e : 1'b0, internal_bus_match_flag_chan2);
        `CHK("irq", e, irq);
        apb(1'b1, OFF_MATCH_FLAGS, 32'h0);
    endtask : hit
    task close_out;
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ticks, num_errors, n_compared} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
        apb(1'b1, OFF_TARGET_ADDR, TA);
        apb(1'b1, OFF_ADDR_MASK, 32'h0000_00f0);
        apb(1'b1, OFF_TARGET_DATA, 32'h0000_a5a5);
        apb(1'b1, OFF_INT_MASK, 32'h0000_5000);
        apb(1'b1, OFF_QUALIFIER, 32'h0000_00ff);
        rd(OFF_TARGET_ADDR, TA);
        rd(OFF_ADDR_MASK, 32'h0000_00f0);
        rd(OFF_TARGET_DATA, 32'h0000_a5a5);
        rd(OFF_QUALIFIER, 32'h0000_00ff);
        rd(8'h1c, 32'h0);
        `CHK("slverr", 1'b1, err_seen);
        hit(8'h7c, 5'h03, 32'h0e0, 32'h0, 1'b1);
        hit(8'h7c, 5'h03, 32'h100, 32'h0, 1'b0);
        hit(8'hbc, 5'h13, 32'h0, 32'h0, 1'b1);
        hit(8'hbc, 5'h03, 32'h0, 32'h0, 1'b0);
        hit(8'hfc, 5'h03, 32'h0, 32'h0, 1'b1);
        hit(8'hfc, 5'h13, 32'h0, 32'h0, 1'b0);
        hit(8'h3c, 5'h03, 32'h0, 32'h0, 1'b0);
        hit(8'h5c, 5'h0b, 32'h0, 32'h0, 1'b1);
        hit(8'h5c, 5'h03, 32'h0, 32'h0, 1'b0);
        hit(8'h6c, 5'h03, 32'h0, 32'h0, 1'b1);
        hit(8'h6c, 5'h0b, 32'h0, 32'h0, 1'b0);
        hit(8'h4c, 5'h0b, 32'h0, 32'h0, 1'b0);
        hit(8'h74, 5'h03, 32'h0, 32'h0, 1'b1);
        hit(8'h74, 5'h07, 32'h0, 32'h0, 1'b0);
        hit(8'h78, 5'h07, 32'h0, 32'h0, 1'b1);
        hit(8'h70, 5'h03, 32'h0, 32'h0, 1'b0);
        hit(8'h7d, 5'h01, 32'h0, 32'hffff_ffa5, 1'b1);
        hit(8'h7d, 5'h01, 32'h0, 32'h0000_00a4, 1'b0);
        hit(8'h7d, 5'h02, 32'h0, 32'h0000_a5a5, 1'b0);
        hit(8'h7e, 5'h02, 32'h0, 32'hffff_a5a5, 1'b1);
        hit(8'h7e, 5'h02, 32'h0, 32'h0000_a4a5, 1'b0);
        hit(8'h7f, 5'h03, 32'h0, 32'h8000_a5a5, 1'b0);
        apb(1'b1, OFF_DATA_MASK, 32'h8000_0000);
        rd(OFF_DATA_MASK, 32'h8000_0000);
        hit(8'h7f, 5'h03, 32'h0, 32'h8000_a5a5, 1'b1);
        apb(1'b1, OFF_QUALIFIER, 32'h0000_007c);
        u_bm.cyc(5'h03, TA, 32'h0);
        rd(OFF_MATCH_FLAGS, 32'h0000_4000);
        apb(1'b1, OFF_MATCH_FLAGS, 32'h0000_5000);
        rd(OFF_MATCH_FLAGS, 32'h0000_4000);
        apb(1'b1, OFF_INT_MASK, 32'h0000_1000);
        #1;
        `CHK("masked irq", 1'b0, irq);
        apb(1'b1, OFF_MATCH_FLAGS, 32'h0);
        rd(OFF_MATCH_FLAGS, 32'h0);
        // Hit lands on the access edge of a clearing write: the set must win
        fork
            apb(1'b1, OFF_MATCH_FLAGS, 32'h0);
            begin
                @(posedge pclk);
                u_bm.cyc(5'h03, TA, 32'h0);
            end
        join
        rd(OFF_MATCH_FLAGS, 32'h0000_4000);
        close_out();
    end
endmodule : tb_top
